/* File: dv/i2c_channel_control_registers_tb.sv */
// self-checking bench of the i2c channel register block
// assumes the engine model and the bound checker beside it
`timescale 1ns/100ps
module i2c_channel_control_registers_tb;
	import i2c_regs_pkg::*;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] tick = 4'h0;
	logic dbg = 1'b0;
	logic slow = 1'b0;
	logic sda = 1'b0;
	logic scl = 1'b0;
	logic push = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	logic [7:0] ev = 8'h00;
	logic [31:0] rdata;
	logic waitreq;
	logic op_tick;
	logic irq;
	logic [7:0] last_tx;
	engine_status_s st;
	engine_control_s ctl;
	logic [15:0] expq[$];
	logic [15:0] cfg[4];
	logic [15:0] msk[4] = '{16'h0133, 16'h0006, 16'h007f, 16'h03ff};
	logic [15:0] tv[7] = '{16'h0000, 16'h0011, 16'h0022, 16'h0033, 16'h0030, 16'h0030, 16'h0130};
	int te[7] = '{16, 16, 4, 16, 2, 0, 2};
	logic [15:0] cmd[3] = '{16'h0025, 16'h0029, 16'h0031};
	logic [15:0] sts[3] = '{16'h0608, 16'h0218, 16'h0218};
	logic [15:0] d;
	int fail_count = 0;
	int compares = 0;
	always #4 clk_sys_in = ~clk_sys_in;

	i2c_channel_control_registers i2c_channel_control_registers_inst (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(1'b1), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(4'h3), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
		.source_tick_in(tick), .debug_mode_in(dbg), .op_tick_out(op_tick),
		.engine_status_in(st), .engine_control_out(ctl), .irq_out(irq));
	i2c_engine_model i2c_engine_model_inst (
		.clk_in(clk_sys_in), .resetn_in(resetn_in), .slow_in(slow), .sda_low_in(sda),
		.scl_low_in(scl), .rx_push_in(push), .rx_byte_in(rx_byte), .event_in(ev),
		.control_in(ctl), .status_out(st), .last_tx_out(last_tx));

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic report_and_stop();
		$display("counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] dv);
		@(posedge clk_sys_in);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= {16'h0000, dv};
		do @(posedge clk_sys_in); while (waitreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdx(input logic [3:0] a, input logic [15:0] e);
		expq.push_back(e);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic pulse(input logic [7:0] e);
		@(posedge clk_sys_in);
		ev <= e;
		@(posedge clk_sys_in);
		ev <= 8'h00;
	endtask
	task automatic tick_run(input logic [15:0] cv, input logic dm, input int e);
		int c;
		c = 0;
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h0000);
		bus(1'b1, IDX_CLOCK_CONTROL, cv);
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h0001);
		dbg <= dm;
		repeat (16) begin
			tick <= 4'($urandom) | (4'h1 << cv[1:0]);
			@(posedge clk_sys_in);
			c += int'(op_tick === 1'b1);
		end
		tick <= 4'h0;
		dbg <= 1'b0;
		chk("op ticks", 16'(e), 16'(c));
	endtask

	// read results leave in request order
	always @(posedge clk_sys_in) begin
		if (rd === 1'b1 && waitreq === 1'b0) begin
			chk("readdata", expq.pop_front(), rdata[15:0]);
			chk("readdata upper", 16'h0000, rdata[31:16]);
		end
	end

	initial begin
		repeat (20000) @(posedge clk_sys_in);
		fail_count++;
		report_and_stop();
	end

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'hfb62_3a9f));
		repeat (2) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		for (int i = 0; i < 10; i++) rdx(4'(i), (i == 2) ? 16'h007f : 16'h0000);
		for (int i = 0; i < 4; i++) begin
			d = 16'($urandom) | 16'h0001;
			cfg[i] = d & msk[i];
			bus(1'b1, 4'(i), d);
			rdx(4'(i), cfg[i]);
		end
		chk("mode", 16'(cfg[1][2:1]), 16'({ctl.addr10, ctl.gc_accept}));
		chk("own", 16'(cfg[3][9:0] & (cfg[1][2] ? 10'h3ff : 10'h07f)), 16'(ctl.own_addr));
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h0001);
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, 4'(i), 16'($urandom) | 16'h0001);
			rdx(4'(i), cfg[i]);
		end
		for (int i = 0; i < 7; i++) tick_run(tv[i], i >= 5, te[i]);
		slow <= 1'b1;
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h000d);
		rdx(IDX_CHANNEL_CONTROL, 16'h0001);
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h0021);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, IDX_CHANNEL_CONTROL, cmd[i]);
			rdx(IDX_CHANNEL_CONTROL, cmd[i]);
			repeat (12) @(posedge clk_sys_in);
			rdx(IDX_CHANNEL_CONTROL, 16'h0021);
			rdx(IDX_STATUS_AND_FLAGS, sts[i]);
		end
		bus(1'b1, IDX_STATUS_AND_FLAGS, 16'h00fc);
		sda <= 1'b1;
		scl <= 1'b1;
		pulse(8'hfc);
		rdx(IDX_STATUS_AND_FLAGS, 16'h1afc);
		bus(1'b1, IDX_STATUS_AND_FLAGS, 16'h0000);
		bus(1'b1, IDX_INTERRUPT_ENABLES, 16'h0080);
		rdx(IDX_STATUS_AND_FLAGS, 16'h1afc);
		chk("irq on", 16'h0001, 16'(irq));
		bus(1'b1, IDX_STATUS_AND_FLAGS, 16'h00d4);
		rdx(IDX_STATUS_AND_FLAGS, 16'h1a28);
		chk("irq off", 16'h0000, 16'(irq));
		d = 16'($urandom) & 16'h00ff;
		@(posedge clk_sys_in);
		rx_byte <= d[7:0];
		push <= 1'b1;
		@(posedge clk_sys_in);
		push <= 1'b0;
		rdx(IDX_STATUS_AND_FLAGS, 16'h1a2a);
		rdx(IDX_INCOMING_BYTE, d);
		rdx(IDX_STATUS_AND_FLAGS, 16'h1a28);
		pulse(8'h01);
		rdx(IDX_STATUS_AND_FLAGS, 16'h1a29);
		d = 16'($urandom) & 16'h00ff;
		bus(1'b1, IDX_OUTGOING_BYTE, d);
		rdx(IDX_STATUS_AND_FLAGS, 16'h1a28);
		chk("tx byte", d, 16'(last_tx));
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h0031);
		pulse(8'hff);
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h0030);
		bus(1'b1, IDX_CHANNEL_CONTROL, 16'h0023);
		rdx(IDX_CHANNEL_CONTROL, 16'h0023);
		repeat (8) @(posedge clk_sys_in);
		rdx(IDX_CHANNEL_CONTROL, 16'h0021);
		rdx(IDX_STATUS_AND_FLAGS, 16'h1a00);
		// mid-run reset: loaded rate and received byte return to reset values
		resetn_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		rdx(IDX_RATE_DIVIDER, 16'h007f);
		rdx(IDX_INCOMING_BYTE, 16'h0000);
		repeat (4) @(posedge clk_sys_in);
		report_and_stop();
	end
endmodule // i2c_channel_control_registers_tb

/* File: dv/i2c_engine_model.sv */
// behavioural bus engine facing the register block
// assumes the block's clock and line levels set by the bench
`timescale 1ns/100ps
module i2c_engine_model
	import i2c_regs_pkg::*;
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic slow_in,
	input wire logic sda_low_in,
	input wire logic scl_low_in,
	input wire logic rx_push_in,
	input wire logic [7:0] rx_byte_in,
	input wire logic [7:0] event_in,
	input wire i2c_regs_pkg::engine_control_s control_in,
	output i2c_regs_pkg::engine_status_s status_out,
	output logic [7:0] last_tx_out
);
	// ------------------------------------------------------------------
	// request handling
	// ------------------------------------------------------------------
	logic [3:0] cnt = 4'h0;
	logic done = 1'b0;
	logic busy = 1'b0;
	logic rx_p = 1'b0;
	logic [7:0] rx_q = 8'h00;
	logic start_d;
	logic stop_d;
	logic nack_d;
	assign start_d = done & control_in.start_req;
	assign stop_d = done & !control_in.start_req & control_in.stop_req;
	assign nack_d = done & !control_in.start_req & !control_in.stop_req & control_in.nack_req;
	always @(posedge clk_in) begin
		done <= 1'b0;
		rx_p <= rx_push_in;
		if (rx_push_in) rx_q <= rx_byte_in;
		if (control_in.tx_written) last_tx_out <= control_in.tx_data;
		if (!resetn_in || control_in.engine_reset) begin
			cnt <= 4'h0;
			busy <= 1'b0;
		end else begin
			if (start_d) busy <= 1'b1;
			if (stop_d) busy <= 1'b0;
			if (cnt == 4'h1) done <= 1'b1;
			// slow mode keeps requests pending long enough to be read back
			if (cnt != 4'h0) cnt <= cnt - 4'h1;
			else if ((control_in.start_req | control_in.stop_req | control_in.nack_req) && !done)
				cnt <= slow_in ? 4'h8 : 4'h1;
		end
	end
	always_comb begin
		status_out = '0;
		status_out.sda_low = sda_low_in;
		status_out.scl_low = scl_low_in;
		status_out.busy = busy;
		status_out.transmitting = control_in.master;
		status_out.start_done = start_d;
		status_out.stop_done = stop_d;
		status_out.nack_done = nack_d;
		status_out.events = event_in | {3'h0, stop_d, start_d, 1'b0, rx_p, 1'b0};
		// released data: last byte in the cycle after the push, its inverse otherwise, never a steady copy
		status_out.rx_data = rx_p ? rx_q : ~rx_q;
	end
endmodule // i2c_engine_model

/* File: dv/i2c_regs_monitor.sv */
// checker of the i2c register block, ports only
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
module i2c_regs_monitor
	import i2c_regs_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic avs_waitrequest_out,
	input wire logic [3:0] source_tick_in,
	input wire logic op_tick_out,
	input wire i2c_regs_pkg::engine_status_s engine_status_in,
	input wire i2c_regs_pkg::engine_control_s engine_control_out
);
	// ------------------------------------------------------------------
	// accepted transfers
	// ------------------------------------------------------------------
	logic take_wr;
	logic take_rd;
	assign take_wr = avs_write_in && !avs_waitrequest_out && ce_in;
	assign take_rd = avs_read_in && !avs_waitrequest_out && ce_in;

	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	property p_rate_reset;
		$rose(resetn_in) |-> engine_control_out.rate == RATE_DIVIDER_RESET;
	endproperty
	a_rate_reset: assert property (p_rate_reset) else $error("rate not at reset value");
	property p_addr7;
		!engine_control_out.addr10 |-> engine_control_out.own_addr[9:7] == 3'h0;
	endproperty
	a_addr7: assert property (p_addr7) else $error("upper address bits leak in 7-bit mode");
	property p_srst_len;
		$rose(engine_control_out.engine_reset) |->
			engine_control_out.engine_reset[*5] ##1 !engine_control_out.engine_reset;
	endproperty
	a_srst_len: assert property (p_srst_len) else $error("soft reset length wrong");
	property p_srst_req;
		$rose(engine_control_out.engine_reset) |=> !engine_control_out.start_req &&
			!engine_control_out.stop_req && !engine_control_out.nack_req;
	endproperty
	a_srst_req: assert property (p_srst_req) else $error("request survives soft reset");
	property p_tx_pulse;
		take_wr && avs_address_in == IDX_OUTGOING_BYTE && avs_byteenable_in[0]
			|=> engine_control_out.tx_written;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("no tx written pulse");
	property p_rx_pulse;
		take_rd && avs_address_in == IDX_INCOMING_BYTE |=> engine_control_out.rx_read;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("no rx read pulse");
	property p_tick_src;
		op_tick_out |-> source_tick_in != 4'h0;
	endproperty
	a_tick_src: assert property (p_tick_src) else $error("op tick without source tick");
	property p_start_master;
		$rose(engine_control_out.start_req) |-> engine_control_out.master;
	endproperty
	a_start_master: assert property (p_start_master) else $error("start request as slave");
	property p_nack_hold;
		engine_control_out.nack_req && !engine_status_in.nack_done && !take_wr &&
			!engine_control_out.engine_reset |=> engine_control_out.nack_req;
	endproperty
	a_nack_hold: assert property (p_nack_hold) else $error("nack request dropped early");
endmodule // i2c_regs_monitor

bind i2c_channel_control_registers i2c_regs_monitor i2c_regs_monitor_inst (
	.clk_sys_in, .resetn_in, .ce_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_byteenable_in, .avs_waitrequest_out, .source_tick_in, .op_tick_out,
	.engine_status_in, .engine_control_out);

/* File: hdl/i2c_channel_control_registers.sv */
// register set of one i2c channel: avalon-mm slave, clock select, flags
// assumes the bus engine gives one-cycle event pulses synchronous to clk_sys_in
`timescale 1ns/100ps

module i2c_channel_control_registers (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [3:0] source_tick_in,
	input wire logic debug_mode_in,
	output logic op_tick_out,
	input wire i2c_regs_pkg::engine_status_s engine_status_in,
	output i2c_regs_pkg::engine_control_s engine_control_out,
	output logic irq_out
);
	import i2c_regs_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic served;
	logic [31:0] readdata;
	logic debug_clock_keep;
	logic [1:0] clock_divider_select;
	logic [1:0] clock_source_select;
	logic address_width_select;
	logic general_call_accept;
	logic [6:0] rate_divider_value;
	logic [9:0] own_address_value;
	logic controller_role_select;
	logic nack_request;
	logic stop_request;
	logic start_request;
	logic block_enable;
	logic [7:0] outgoing_byte;
	logic [7:0] incoming_byte;
	logic [7:0] flags;
	logic [7:0] interrupt_enables;
	soft_reset_e sr_state;
	logic [2:0] sr_count;
	logic [2:0] div_count;
	logic tx_written;
	logic rx_read;

	logic next_served;
	logic [31:0] next_readdata;
	logic next_debug_clock_keep;
	logic [1:0] next_clock_divider_select;
	logic [1:0] next_clock_source_select;
	logic next_address_width_select;
	logic next_general_call_accept;
	logic [6:0] next_rate_divider_value;
	logic [9:0] next_own_address_value;
	logic next_controller_role_select;
	logic next_nack_request;
	logic next_stop_request;
	logic next_start_request;
	logic next_block_enable;
	logic [7:0] next_outgoing_byte;
	logic [7:0] next_incoming_byte;
	logic [7:0] next_flags;
	logic [7:0] next_interrupt_enables;
	soft_reset_e next_sr_state;
	logic [2:0] next_sr_count;
	logic [2:0] next_div_count;
	logic next_tx_written;
	logic next_rx_read;

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	logic request;
	logic accept_wr;
	logic accept_rd;
	logic [15:0] wmask;
	logic [15:0] wdata;
	logic cfg_open;
	logic soft_reset_busy;
	logic [7:0] flag_clear;
	logic [15:0] status_word;

	// one wait state: data is staged on the first edge, taken on the second
	assign request = avs_read_in | avs_write_in;
	// a frozen clock keeps the master waiting, so no transfer is lost
	assign avs_waitrequest_out = request & ~(served & ce_in);
	assign accept_wr = avs_write_in & served;
	assign accept_rd = avs_read_in & served;
	assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	assign wdata = avs_writedata_in[15:0] & wmask;
	assign avs_readdata_out = readdata;
	assign cfg_open = ~block_enable;
	assign soft_reset_busy = (sr_state != SR_IDLE);

	assign status_word = {3'b000,
		engine_status_in.sda_low,
		engine_status_in.scl_low,
		engine_status_in.busy & ~soft_reset_busy,
		engine_status_in.transmitting,
		1'b0,
		flags};

	// ------------------------------------------------------------------
	// cause flags
	// ------------------------------------------------------------------
	// an event in the clearing cycle survives; soft reset alone overrides
	always_comb begin
		flag_clear = 8'h00;
		if (accept_wr && avs_address_in == IDX_STATUS_AND_FLAGS) begin
			flag_clear[7:FIRST_W1C_FLAG] = wdata[7:FIRST_W1C_FLAG];
		end
		if (accept_rd && avs_address_in == IDX_INCOMING_BYTE) begin
			flag_clear[POS_RECEIVE_FULL_FLAG] = 1'b1;
		end
		if (accept_wr && avs_address_in == IDX_OUTGOING_BYTE && avs_byteenable_in[0]) begin
			flag_clear[POS_TRANSMIT_EMPTY_FLAG] = 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			assign next_flags[gi] = soft_reset_busy ? 1'b0 :
				(engine_status_in.events[gi] | (flags[gi] & ~flag_clear[gi]));
		end
	endgenerate

	assign irq_out = |(flags & interrupt_enables);

	// ------------------------------------------------------------------
	// operating clock
	// ------------------------------------------------------------------
	logic selected_tick;
	logic clock_allowed;
	logic [2:0] div_mask;
	logic divide_hit;

	assign selected_tick = source_tick_in[clock_source_select];
	assign clock_allowed = block_enable & (~debug_mode_in | debug_clock_keep);

	always_comb begin
		div_mask = 3'h0;
		if (clock_source_select == SRC_INTERNAL_OSCILLATOR ||
				clock_source_select == SRC_HIGH_SPEED_OSCILLATOR) begin
			case (clock_divider_select)
				2'h0: div_mask = 3'h0;
				2'h1: div_mask = 3'h1;
				2'h2: div_mask = 3'h3;
				2'h3: div_mask = 3'h7;
				default: div_mask = 3'h0;
			endcase
		end
	end

	assign divide_hit = ((div_count & div_mask) == div_mask);
	assign op_tick_out = clock_allowed & selected_tick & divide_hit;

	// ------------------------------------------------------------------
	// engine control
	// ------------------------------------------------------------------
	always_comb begin
		engine_control_out.master = controller_role_select;
		engine_control_out.addr10 = address_width_select;
		engine_control_out.gc_accept = general_call_accept;
		engine_control_out.own_addr = address_width_select ? own_address_value :
			{3'b000, own_address_value[6:0]};
		engine_control_out.rate = rate_divider_value;
		engine_control_out.start_req = start_request;
		engine_control_out.stop_req = stop_request;
		engine_control_out.nack_req = nack_request;
		engine_control_out.tx_data = outgoing_byte;
		engine_control_out.tx_written = tx_written;
		engine_control_out.rx_read = rx_read;
		engine_control_out.engine_reset = soft_reset_busy;
	end

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		next_served = request & ~served;
		next_readdata = readdata;
		next_debug_clock_keep = debug_clock_keep;
		next_clock_divider_select = clock_divider_select;
		next_clock_source_select = clock_source_select;
		next_address_width_select = address_width_select;
		next_general_call_accept = general_call_accept;
		next_rate_divider_value = rate_divider_value;
		next_own_address_value = own_address_value;
		next_controller_role_select = controller_role_select;
		next_nack_request = nack_request;
		next_stop_request = stop_request;
		next_start_request = start_request;
		next_block_enable = block_enable;
		next_outgoing_byte = outgoing_byte;
		next_incoming_byte = incoming_byte;
		next_interrupt_enables = interrupt_enables;
		next_sr_state = sr_state;
		next_sr_count = sr_count;
		next_div_count = div_count;
		next_tx_written = 1'b0;
		next_rx_read = accept_rd && avs_address_in == IDX_INCOMING_BYTE;

		// engine completions clear the requests
		if (engine_status_in.nack_done) next_nack_request = 1'b0;
		if (engine_status_in.stop_done) next_stop_request = 1'b0;
		if (engine_status_in.start_done || engine_status_in.start_abort) begin
			next_start_request = 1'b0;
		end
		if (engine_status_in.events[POS_RECEIVE_FULL_FLAG]) begin
			next_incoming_byte = engine_status_in.rx_data;
		end

		// staged read data, held through the accepting cycle
		if (avs_read_in && !served) begin
			case (avs_address_in)
				IDX_CLOCK_CONTROL: next_readdata = {23'h00_0000, debug_clock_keep,
					2'b00, clock_divider_select, 2'b00, clock_source_select};
				IDX_MODE_SETTING: next_readdata = {29'h0000_0000, address_width_select,
					general_call_accept, 1'b0};
				IDX_RATE_DIVIDER: next_readdata = {25'h000_0000, rate_divider_value};
				IDX_OWN_SLAVE_ID: next_readdata = {22'h00_0000, own_address_value};
				IDX_CHANNEL_CONTROL: next_readdata = {26'h000_0000, controller_role_select,
					nack_request, stop_request, start_request, soft_reset_busy, block_enable};
				IDX_OUTGOING_BYTE: next_readdata = {24'h00_0000, outgoing_byte};
				IDX_INCOMING_BYTE: next_readdata = {24'h00_0000, incoming_byte};
				IDX_STATUS_AND_FLAGS: next_readdata = {16'h0000, status_word};
				IDX_INTERRUPT_ENABLES: next_readdata = {24'h00_0000, interrupt_enables};
				default: next_readdata = 32'h0000_0000;
			endcase
		end

		if (accept_wr) begin
			case (avs_address_in)
				IDX_CLOCK_CONTROL: begin
					if (cfg_open) begin
						if (wmask[8]) next_debug_clock_keep = wdata[POS_DEBUG_CLOCK_KEEP];
						if (wmask[0]) begin
							next_clock_divider_select = wdata[POS_CLOCK_DIVIDER_SELECT +: 2];
							// a source the part lacks keeps the old choice
							if (SOURCES_SUPPORTED[wdata[POS_CLOCK_SOURCE_SELECT +: 2]]) begin
								next_clock_source_select = wdata[POS_CLOCK_SOURCE_SELECT +: 2];
							end
						end
					end
				end
				IDX_MODE_SETTING: begin
					if (cfg_open && wmask[0]) begin
						next_address_width_select = wdata[POS_ADDRESS_WIDTH_SELECT];
						next_general_call_accept = wdata[POS_GENERAL_CALL_ACCEPT];
					end
				end
				IDX_RATE_DIVIDER: begin
					if (cfg_open && wmask[0]) next_rate_divider_value = wdata[6:0];
				end
				IDX_OWN_SLAVE_ID: begin
					if (cfg_open) begin
						if (wmask[0]) next_own_address_value[7:0] = wdata[7:0];
						if (wmask[8]) next_own_address_value[9:8] = wdata[9:8];
					end
				end
				IDX_CHANNEL_CONTROL: begin
					if (wmask[0]) begin
						next_controller_role_select = wdata[POS_CONTROLLER_ROLE_SELECT];
						next_block_enable = wdata[POS_BLOCK_ENABLE];
						if (wdata[POS_NACK_REQUEST]) next_nack_request = 1'b1;
						// stop and start requests are dropped in slave mode
						if (wdata[POS_STOP_REQUEST] && controller_role_select) begin
							next_stop_request = 1'b1;
						end
						if (wdata[POS_START_REQUEST] && controller_role_select) begin
							next_start_request = 1'b1;
						end
						if (wdata[POS_SOFT_RESET]) begin
							next_sr_state = SR_HOLD;
							next_sr_count = SOFT_RESET_CYCLES;
						end
					end
				end
				IDX_OUTGOING_BYTE: begin
					if (wmask[0]) begin
						next_outgoing_byte = wdata[7:0];
						next_tx_written = 1'b1;
					end
				end
				IDX_INTERRUPT_ENABLES: begin
					if (wmask[0]) next_interrupt_enables = wdata[7:0];
				end
				default: begin
				end
			endcase
		end

		// soft reset sequence
		case (sr_state)
			SR_IDLE: begin
			end
			SR_HOLD: begin
				next_nack_request = 1'b0;
				next_stop_request = 1'b0;
				next_start_request = 1'b0;
				next_sr_count = sr_count - 3'h1;
				if (sr_count == 3'h1) next_sr_state = SR_DONE;
			end
			SR_DONE: begin
				next_sr_state = SR_IDLE;
			end
			default: next_sr_state = SR_IDLE;
		endcase

		// divider runs only on ticks that reach the channel
		if (clock_allowed && selected_tick) begin
			next_div_count = div_count + 3'h1;
		end
		if (!block_enable) next_div_count = 3'h0;
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			served <= 1'b0;
			readdata <= 32'h0000_0000;
			debug_clock_keep <= 1'b0;
			clock_divider_select <= 2'h0;
			clock_source_select <= SRC_INTERNAL_OSCILLATOR;
			address_width_select <= 1'b0;
			general_call_accept <= 1'b0;
			rate_divider_value <= RATE_DIVIDER_RESET;
			own_address_value <= 10'h000;
			controller_role_select <= 1'b0;
			nack_request <= 1'b0;
			stop_request <= 1'b0;
			start_request <= 1'b0;
			block_enable <= 1'b0;
			outgoing_byte <= 8'h00;
			incoming_byte <= 8'h00;
			flags <= 8'h00;
			interrupt_enables <= 8'h00;
			sr_state <= SR_IDLE;
			sr_count <= 3'h0;
			div_count <= 3'h0;
			tx_written <= 1'b0;
			rx_read <= 1'b0;
		end else if (ce_in) begin
			served <= next_served;
			readdata <= next_readdata;
			debug_clock_keep <= next_debug_clock_keep;
			clock_divider_select <= next_clock_divider_select;
			clock_source_select <= next_clock_source_select;
			address_width_select <= next_address_width_select;
			general_call_accept <= next_general_call_accept;
			rate_divider_value <= next_rate_divider_value;
			own_address_value <= next_own_address_value;
			controller_role_select <= next_controller_role_select;
			nack_request <= next_nack_request;
			stop_request <= next_stop_request;
			start_request <= next_start_request;
			block_enable <= next_block_enable;
			outgoing_byte <= next_outgoing_byte;
			incoming_byte <= next_incoming_byte;
			flags <= next_flags;
			interrupt_enables <= next_interrupt_enables;
			sr_state <= next_sr_state;
			sr_count <= next_sr_count;
			div_count <= next_div_count;
			tx_written <= next_tx_written;
			rx_read <= next_rx_read;
		end
	end

endmodule // i2c_channel_control_registers

/* File: hdl/i2c_regs_pkg.sv */
// constants, field layouts and carriers of the i2c channel register block
// assumes a word-addressed avalon-mm slave port and an external bus engine
package i2c_regs_pkg;

	// ------------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [3:0] IDX_CLOCK_CONTROL = 4'h0;
	localparam logic [3:0] IDX_MODE_SETTING = 4'h1;
	localparam logic [3:0] IDX_RATE_DIVIDER = 4'h2;
	localparam logic [3:0] IDX_OWN_SLAVE_ID = 4'h3;
	localparam logic [3:0] IDX_CHANNEL_CONTROL = 4'h4;
	localparam logic [3:0] IDX_OUTGOING_BYTE = 4'h5;
	localparam logic [3:0] IDX_INCOMING_BYTE = 4'h6;
	localparam logic [3:0] IDX_STATUS_AND_FLAGS = 4'h7;
	localparam logic [3:0] IDX_INTERRUPT_ENABLES = 4'h8;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int POS_DEBUG_CLOCK_KEEP = 8;
	localparam int POS_CLOCK_DIVIDER_SELECT = 4;
	localparam int POS_CLOCK_SOURCE_SELECT = 0;
	localparam int POS_ADDRESS_WIDTH_SELECT = 2;
	localparam int POS_GENERAL_CALL_ACCEPT = 1;
	localparam int POS_CONTROLLER_ROLE_SELECT = 5;
	localparam int POS_NACK_REQUEST = 4;
	localparam int POS_STOP_REQUEST = 3;
	localparam int POS_START_REQUEST = 2;
	localparam int POS_SOFT_RESET = 1;
	localparam int POS_BLOCK_ENABLE = 0;
	localparam int POS_DATA_LINE_LOW = 12;
	localparam int POS_CLOCK_LINE_LOW = 11;
	localparam int POS_LINE_OCCUPIED = 10;
	localparam int POS_SENDING_ROLE = 9;
	localparam int POS_RECEIVE_FULL_FLAG = 1;
	localparam int POS_TRANSMIT_EMPTY_FLAG = 0;
	localparam int FIRST_W1C_FLAG = 2;

	// ------------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------------
	localparam logic [6:0] RATE_DIVIDER_RESET = 7'h7f;
	localparam logic [1:0] SRC_INTERNAL_OSCILLATOR = 2'h0;
	localparam logic [1:0] SRC_LOW_SPEED_CRYSTAL = 2'h1;
	localparam logic [1:0] SRC_HIGH_SPEED_OSCILLATOR = 2'h2;
	localparam logic [1:0] SRC_EXTERNAL_CLOCK_INPUT = 2'h3;
	localparam logic [3:0] SOURCES_SUPPORTED = 4'hf;
	localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;

	typedef enum logic [1:0] {
		SR_IDLE = 2'b00,
		SR_HOLD = 2'b01,
		SR_DONE = 2'b11
	} soft_reset_e;

	// ------------------------------------------------------------------
	// carriers to and from the bus engine
	// ------------------------------------------------------------------
	typedef struct packed {
		logic sda_low;
		logic scl_low;
		logic busy;
		logic transmitting;
		logic [7:0] events;
		logic [7:0] rx_data;
		logic start_done;
		logic start_abort;
		logic stop_done;
		logic nack_done;
	} engine_status_s;

	typedef struct packed {
		logic master;
		logic addr10;
		logic gc_accept;
		logic [9:0] own_addr;
		logic [6:0] rate;
		logic start_req;
		logic stop_req;
		logic nack_req;
		logic [7:0] tx_data;
		logic tx_written;
		logic rx_read;
		logic engine_reset;
	} engine_control_s;

endpackage
